/* File: core/tsf_consts.vh */
// constants for the temperature sample fifo control block
// assumes an 8-bit register port decoded by an upstream serial slave
//
// Contract
// - almost-full asserts when free space equals the 6-bit threshold field
// - flush write discards contents, zeroes both indices and the sample count
// - flush bit clears itself after the flush is done
// - overwrite-on-full set: pushes into a full fifo continue, oldest lost
// - while overwriting, write and read indices both advance per sample
// - overwrite-on-full clear: pushes into a full fifo are refused
// - a refused sample leaves write and read indices unchanged
// - auto or external conversion with change detect forces overwrite on full
// - writing one to the soft-reset bit restores all register defaults
// - soft-reset bit clears itself once the reset has acted
// - lost samples counted in a 6-bit tally saturating at 0x3f
// - write index advances once per pushed sample, pointing at next slot
// - 7-bit count equals samples available to the host
`ifndef TSF_CONSTS_VH
`define TSF_CONSTS_VH

`define TSF_ADDR_WR_IDX     8'h04
`define TSF_ADDR_RD_IDX     8'h05
`define TSF_ADDR_LOST       8'h06
`define TSF_ADDR_COUNT      8'h07
`define TSF_ADDR_DATA       8'h08
`define TSF_ADDR_THRESH     8'h09
`define TSF_ADDR_CTRL       8'h0a
`define TSF_ADDR_SRST       8'h11

`define TSF_THRESH_RESET    6'h1f
`define TSF_CTRL_RESET      3'h0
`define TSF_BIT_OVERWRITE   1
`define TSF_BIT_TYPE        2
`define TSF_BIT_STATCLR     3
`define TSF_BIT_FLUSH       4
`define TSF_BIT_SRST        0
`define TSF_LOST_MAX        6'h3f
`define TSF_DEPTH           7'h40

`endif

/* File: core/tsf_ctrl.v */
// index and count bookkeeping for the sample fifo
// assumes push and pop are one-cycle pulses on core_clk_in
`timescale 1ns/100ps
`include "tsf_consts.vh"
module tsf_ctrl (
   input  wire       core_clk_in,
   input  wire       clear_in,
   input  wire       push_in,
   input  wire       pop_in,
   input  wire       overwrite_in,
   output wire       write_en_out,
   output reg  [5:0] write_index_out,
   output reg  [5:0] read_index_out,
   output reg  [6:0] count_out,
   output reg  [5:0] lost_out
);
   wire full_w  = (count_out == `TSF_DEPTH);
   wire empty_w = (count_out == 7'h00);
   wire do_pop  = pop_in && !empty_w;
   // a pop in the same cycle frees a slot, so the push is never lost then
   wire room_w  = !full_w || do_pop;
   wire roll_w  = push_in && !room_w && overwrite_in;
   wire drop_w  = push_in && !room_w && !overwrite_in;
   wire do_push = push_in && (room_w || overwrite_in);

   assign write_en_out = do_push;

   always @(posedge core_clk_in) begin
      if (clear_in) begin
         write_index_out <= 6'h00;
         read_index_out  <= 6'h00;
         count_out       <= 7'h00;
         lost_out        <= 6'h00;
      end else begin
         if (do_push)
            write_index_out <= write_index_out + 6'h01;
         if (do_pop || roll_w)
            read_index_out <= read_index_out + 6'h01;
         if (do_push && !do_pop && !roll_w)
            count_out <= count_out + 7'h01;
         else if (do_pop && !do_push)
            count_out <= count_out - 7'h01;
         if ((roll_w || drop_w) && lost_out != `TSF_LOST_MAX)
            lost_out <= lost_out + 6'h01;
      end
   end
endmodule

/* File: core/tsf_top.v */
// register front and sample store of the temperature sample fifo
// assumes a decoded 8-bit register port with one-cycle read/write strobes
`timescale 1ns/100ps
`include "tsf_consts.vh"
module tsf_top #(
   parameter DATA_W = 8
) (
   input  wire              core_clk_in,
   input  wire              srst_in,
   input  wire [7:0]        reg_addr_in,
   input  wire [7:0]        reg_wdata_in,
   input  wire              reg_wr_in,
   input  wire              reg_rd_in,
   output reg  [7:0]        reg_rdata_out,
   input  wire              sample_valid_in,
   input  wire [DATA_W-1:0] sample_data_in,
   input  wire              auto_or_ext_mode_in,
   input  wire              change_detect_enable_in,
   output wire              almost_full_out,
   output reg  [DATA_W-1:0] pop_data_out
);
   reg  [5:0] thresh_reg;
   reg  [5:0] thresh_next;
   reg  [3:1] ctrl_reg;
   reg  [3:1] ctrl_next;
   reg        flush_reg;
   reg        flush_next;
   reg        soft_rst_reg;
   reg        soft_rst_next;
   reg  [DATA_W-1:0] mem [0:63];
   wire [5:0] write_index;
   wire [5:0] read_index;
   wire [6:0] count;
   wire [5:0] lost_sample_tally;
   wire       write_en;
   wire       overwrite_on_full;
   wire       pop;
   wire       wr_thresh;
   wire       wr_ctrl;
   wire       wr_srst;

   assign wr_thresh = reg_wr_in && (reg_addr_in == `TSF_ADDR_THRESH);
   assign wr_ctrl   = reg_wr_in && (reg_addr_in == `TSF_ADDR_CTRL);
   assign wr_srst   = reg_wr_in && (reg_addr_in == `TSF_ADDR_SRST);
   assign pop       = reg_rd_in && (reg_addr_in == `TSF_ADDR_DATA);

   // change detect in autonomous modes must never stall on full
   assign overwrite_on_full = ctrl_reg[`TSF_BIT_OVERWRITE] ||
                              (auto_or_ext_mode_in && change_detect_enable_in);

   // free space = 64 - count; compare in 7 bits so an empty fifo never matches
   assign almost_full_out = ((`TSF_DEPTH - count) == {1'b0, thresh_reg});

   always @* begin
      thresh_next   = thresh_reg;
      ctrl_next     = ctrl_reg;
      flush_next    = 1'b0;
      soft_rst_next = 1'b0;
      if (soft_rst_reg) begin
         thresh_next = `TSF_THRESH_RESET;
         ctrl_next   = `TSF_CTRL_RESET;
      end else if (wr_srst && reg_wdata_in[`TSF_BIT_SRST]) begin
         soft_rst_next = 1'b1;
      end else if (wr_thresh) begin
         thresh_next = reg_wdata_in[5:0];
      end else if (wr_ctrl) begin
         ctrl_next  = reg_wdata_in[3:1];
         flush_next = reg_wdata_in[`TSF_BIT_FLUSH];
      end
   end

   always @(posedge core_clk_in) begin
      if (srst_in) begin
         thresh_reg   <= `TSF_THRESH_RESET;
         ctrl_reg     <= `TSF_CTRL_RESET;
         flush_reg    <= 1'b0;
         soft_rst_reg <= 1'b0;
      end else begin
         thresh_reg   <= thresh_next;
         ctrl_reg     <= ctrl_next;
         flush_reg    <= flush_next;
         soft_rst_reg <= soft_rst_next;
      end
   end

   always @(posedge core_clk_in) begin
      if (write_en)
         mem[write_index] <= sample_data_in;
   end

   always @(posedge core_clk_in) begin
      if (srst_in || soft_rst_reg)
         pop_data_out <= {DATA_W{1'b0}};
      else if (pop && count != 7'h00)
         pop_data_out <= mem[read_index];
   end

   tsf_ctrl u_ctrl (
      .core_clk_in     (core_clk_in),
      .clear_in        (srst_in || soft_rst_reg || flush_reg),
      .push_in         (sample_valid_in),
      .pop_in          (pop),
      .overwrite_in    (overwrite_on_full),
      .write_en_out    (write_en),
      .write_index_out (write_index),
      .read_index_out  (read_index),
      .count_out       (count),
      .lost_out        (lost_sample_tally)
   );

   always @(posedge core_clk_in) begin
      if (srst_in) begin
         reg_rdata_out <= 8'h00;
      end else if (!reg_rd_in) begin
         reg_rdata_out <= reg_rdata_out;
      end else if (reg_addr_in == `TSF_ADDR_WR_IDX) begin
         reg_rdata_out <= {2'h0, write_index};
      end else if (reg_addr_in == `TSF_ADDR_RD_IDX) begin
         reg_rdata_out <= {2'h0, read_index};
      end else if (reg_addr_in == `TSF_ADDR_LOST) begin
         reg_rdata_out <= {2'h0, lost_sample_tally};
      end else if (reg_addr_in == `TSF_ADDR_COUNT) begin
         reg_rdata_out <= {1'b0, count};
      end else if (reg_addr_in == `TSF_ADDR_THRESH) begin
         reg_rdata_out <= {2'h0, thresh_reg};
      end else if (reg_addr_in == `TSF_ADDR_CTRL) begin
         reg_rdata_out <= {3'h0, flush_reg, ctrl_reg, 1'b0};
      end else begin
         reg_rdata_out <= 8'h00;
      end
   end
endmodule

/* File: dv/tsf_monitor.sv */
// port checker for tsf_top
// assumes one-cycle register strobes and no push during flush
`timescale 1ns/100ps
module tsf_monitor (
   input wire       core_clk_in,
   input wire       srst_in,
   input wire [7:0] reg_addr_in,
   input wire [7:0] reg_wdata_in,
   input wire       reg_wr_in,
   input wire       reg_rd_in,
   input wire [7:0] reg_rdata_out,
   input wire       sample_valid_in,
   input wire       almost_full_out
);
   default clocking @(posedge core_clk_in); endclocking
   default disable iff (srst_in);
   wire rd_cnt = reg_rd_in && reg_addr_in == 8'h07;
   wire rd_ctl = reg_rd_in && reg_addr_in == 8'h0a;
   wire rd_idx = reg_rd_in && reg_addr_in >= 8'h04 && reg_addr_in <= 8'h06;
   wire wr_fl  = reg_wr_in && reg_addr_in == 8'h0a && reg_wdata_in[4];
   wire wr_sr  = reg_wr_in && reg_addr_in == 8'h11 && reg_wdata_in[0];
   property p_srst_rd; reg_rd_in && reg_addr_in == 8'h11 |=> reg_rdata_out == 8'h00; endproperty
   a_srst_rd: assert property (p_srst_rd) else $error("soft reset reg not zero");
   property p_flush_cnt; (wr_fl && !sample_valid_in) ##1 !sample_valid_in ##1
      (rd_cnt && !sample_valid_in) |=> reg_rdata_out == 8'h00; endproperty
   a_flush_cnt: assert property (p_flush_cnt) else $error("count after flush");
   property p_flush_self; wr_fl ##2 rd_ctl |=> !reg_rdata_out[4]; endproperty
   a_flush_self: assert property (p_flush_self) else $error("flush bit stuck");
   property p_soft_thr; wr_sr ##3 (reg_rd_in && reg_addr_in == 8'h09) |=> reg_rdata_out == 8'h1f;
   endproperty
   a_soft_thr: assert property (p_soft_thr) else $error("threshold not default");
   property p_idx_w; rd_idx |=> reg_rdata_out[7:6] == 2'b00; endproperty
   a_idx_w: assert property (p_idx_w) else $error("index width");
   property p_cnt_w; rd_cnt |=> reg_rdata_out <= 8'h40; endproperty
   a_cnt_w: assert property (p_cnt_w) else $error("count above depth");
   property p_ctl_w; rd_ctl |=> reg_rdata_out[7:5] == 3'b000 && !reg_rdata_out[0]; endproperty
   a_ctl_w: assert property (p_ctl_w) else $error("unused ctrl bits");
   // flush and soft reset act two edges late
   property p_af_cause; !$stable(almost_full_out) |-> $past(sample_valid_in) || $past(reg_rd_in)
      || $past(reg_wr_in) || $past(reg_wr_in, 2); endproperty
   a_af_cause: assert property (p_af_cause) else $error("almost full without cause");
endmodule

/* File: dv/tsf_host.sv */
// host register master model
// assumes strobes sampled on the rising clock edge
`timescale 1ns/100ps
module tsf_host (
   input  wire       core_clk_in,
   input  wire [7:0] reg_rdata_in,
   output reg  [7:0] reg_addr_out  = 8'h00,
   output reg  [7:0] reg_wdata_out = 8'h00,
   output reg        reg_wr_out    = 1'b0,
   output reg        reg_rd_out    = 1'b0
);
   task wr(input [7:0] a, input [7:0] v);
      begin
         @(negedge core_clk_in);
         {reg_addr_out, reg_wdata_out, reg_wr_out} = {a, v, 1'b1};
         @(negedge core_clk_in);
         // released data shows no stale value
         {reg_wdata_out, reg_wr_out} = {~v, 1'b0};
      end
   endtask
   task rd(input [7:0] a, output [7:0] v);
      begin
         @(negedge core_clk_in);
         {reg_addr_out, reg_rd_out} = {a, 1'b1};
         @(negedge core_clk_in);
         reg_rd_out = 1'b0;
         v = reg_rdata_in;
      end
   endtask
endmodule

/* File: dv/tsf_tb_top.sv */
// testbench for tsf_top
// assumes the host model drives the register port
`timescale 1ns/100ps
module tsf_tb_top;
   reg         core_clk_in = 1'b0;
   reg         srst_in = 1'b1;
   reg         sample_valid_in = 1'b0;
   reg  [7:0]  sample_data_in = 8'h00;
   reg         auto_or_ext_mode_in = 1'b0;
   reg         change_detect_enable_in = 1'b0;
   wire [7:0]  reg_addr_in, reg_wdata_in, reg_rdata_out, pop_data_out;
   wire        reg_wr_in, reg_rd_in, almost_full_out;
   integer     fails = 0;
   integer     check_count = 0;
   integer     i;
   reg  [7:0]  d;
   reg  [23:0] rows [0:4];
   always #25 core_clk_in = ~core_clk_in;
   tsf_host host_u (.core_clk_in, .reg_rdata_in(reg_rdata_out), .reg_addr_out(reg_addr_in),
      .reg_wdata_out(reg_wdata_in), .reg_wr_out(reg_wr_in), .reg_rd_out(reg_rd_in));
   tsf_top dut_u (.core_clk_in, .srst_in, .reg_addr_in, .reg_wdata_in, .reg_wr_in, .reg_rd_in,
      .reg_rdata_out, .sample_valid_in, .sample_data_in, .auto_or_ext_mode_in,
      .change_detect_enable_in, .almost_full_out, .pop_data_out);
   task chk(input [7:0] seen, input [7:0] exp);
      begin
         check_count = check_count + 1;
         if (seen !== exp) begin
            fails = fails + 1;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
         end
      end
   endtask
   task rdc(input [7:0] a, input [7:0] exp);
      begin
         host_u.rd(a, d);
         chk(d, exp);
      end
   endtask
   task push(input [7:0] v);
      begin
         @(negedge core_clk_in);
         {sample_valid_in, sample_data_in} = {1'b1, v};
         @(negedge core_clk_in);
         {sample_valid_in, sample_data_in} = {1'b0, ~v};
      end
   endtask
   task summarize;
      begin
         if (fails == 0 && check_count > 0)
            $display("verification passed");
         else
            $display("verification failed");
         $finish;
      end
   endtask
   initial begin
      rows[0] = {8'h09, 8'hff, 8'h3f};
      rows[1] = {8'h0a, 8'hee, 8'h0e};
      rows[2] = {8'h04, 8'hff, 8'h00};
      rows[3] = {8'h11, 8'h00, 8'h00};
      rows[4] = {8'h30, 8'h5a, 8'h00};
      repeat (2) @(negedge core_clk_in);
      srst_in = 1'b0;
      rdc(8'h09, 8'h1f);
      for (i = 0; i < 5; i = i + 1) begin
         host_u.wr(rows[i][23:16], rows[i][15:8]);
         rdc(rows[i][23:16], rows[i][7:0]);
      end
      // soft reset undoes the row writes
      host_u.wr(8'h11, 8'h01);
      repeat (2) @(negedge core_clk_in);
      rdc(8'h09, 8'h1f);
      rdc(8'h0a, 8'h00);
      rdc(8'h11, 8'h00);
      // fill with overwrite off
      for (i = 0; i < 64; i = i + 1) begin
         push(i[7:0] + 8'h01);
         if (i == 31)
            chk({7'h00, almost_full_out}, 8'h00);
         if (i == 32)
            chk({7'h00, almost_full_out}, 8'h01);
      end
      rdc(8'h07, 8'h40);
      rdc(8'h04, 8'h00);
      push(8'haa);
      rdc(8'h06, 8'h01);
      rdc(8'h04, 8'h00);
      rdc(8'h05, 8'h00);
      rdc(8'h07, 8'h40);
      rdc(8'h08, 8'h00);
      chk(pop_data_out, 8'h01);
      rdc(8'h07, 8'h3f);
      // overwrite on: second push rolls over the oldest sample
      host_u.wr(8'h0a, 8'h02);
      push(8'h41);
      push(8'h42);
      rdc(8'h04, 8'h02);
      rdc(8'h05, 8'h02);
      rdc(8'h06, 8'h02);
      rdc(8'h07, 8'h40);
      rdc(8'h08, 8'h00);
      chk(pop_data_out, 8'h03);
      // forced roll with overwrite bit clear
      host_u.wr(8'h0a, 8'h00);
      auto_or_ext_mode_in = 1'b1;
      change_detect_enable_in = 1'b1;
      push(8'h43);
      push(8'h44);
      rdc(8'h05, 8'h04);
      rdc(8'h04, 8'h04);
      auto_or_ext_mode_in = 1'b0;
      change_detect_enable_in = 1'b0;
      // flush
      host_u.wr(8'h0a, 8'h10);
      rdc(8'h07, 8'h00);
      rdc(8'h04, 8'h00);
      rdc(8'h05, 8'h00);
      rdc(8'h0a, 8'h00);
      // pin reset in mid-run
      host_u.wr(8'h09, 8'h05);
      @(negedge core_clk_in);
      srst_in = 1'b1;
      repeat (2) @(negedge core_clk_in);
      srst_in = 1'b0;
      chk(pop_data_out, 8'h00);
      rdc(8'h09, 8'h1f);
      summarize;
   end
endmodule
bind tsf_top tsf_monitor mon_u (.core_clk_in, .srst_in, .reg_addr_in, .reg_wdata_in, .reg_wr_in,
   .reg_rd_in, .reg_rdata_out, .sample_valid_in, .almost_full_out);
